// ### rtl/pslv_pkg.sv
package pslv_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_DATA_LATCH  = 8'h08;
	localparam logic [7:0] IDX_CTL_PINS    = 8'h09;
	localparam logic [7:0] IDX_FLAG_REG    = 8'h0C;
	localparam logic [7:0] IDX_DIR_STATUS  = 8'h89;
	localparam logic [7:0] IDX_ENABLE_REG  = 8'h8C;
	localparam logic [7:0] IDX_CONV_CFG    = 8'h9F;

	localparam int         ADDR_W          = 10;
	localparam int         DATA_W          = 8;

	// field positions
	localparam int         BIT_XFER_IRQ    = 7;
	localparam int         BIT_IN_FULL     = 7;
	localparam int         BIT_OUT_FULL    = 6;
	localparam int         BIT_IN_OVF      = 5;
	localparam int         BIT_MODE        = 4;
	localparam int         CTL_RD          = 0;
	localparam int         CTL_WR          = 1;
	localparam int         CTL_CS          = 2;

	// reset values, and the conv_cfg_r code for all pins digital
	localparam logic [2:0] DIR_RESET       = 3'h7;
	localparam logic [7:0] REG8_RESET      = 8'h00;
	localparam logic [3:0] CFG_ALL_DIGITAL = 4'hF;

	// core clock phase positions in the four-cycle instruction frame
	localparam logic [1:0] PHASE_TWO       = 2'h1;
	localparam logic [1:0] PHASE_FOUR      = 2'h3;

	typedef enum logic [1:0] {
		DONE_IDLE,
		DONE_WAIT_TWO,
		DONE_WAIT_FOUR
	} pslv_done_t;

	typedef struct packed {
		logic       input_full_flag;
		logic       output_full_flag;
		logic       input_overflow_flag;
		logic       slave_mode_select;
		logic       pin3_direction_stub;
		logic [2:0] pin_direction;
	} pslv_dir_status_t;

endpackage

// ### rtl/pslv_port.sv
`timescale 1ns/100ps

module pslv_port
(
	// apb slave
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [pslv_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// data port pins
	input  wire logic [pslv_pkg::DATA_W-1:0]   data_in,
	output logic      [pslv_pkg::DATA_W-1:0]   data_out,
	output logic      [pslv_pkg::DATA_W-1:0]   data_oe,
	// control port pins
	input  wire logic [3:0]                    ctl_in,
	output logic      [2:0]                    ctl_out,
	output logic      [2:0]                    ctl_oe,
	// interrupt request
	output logic                               transfer_irq
);

	logic [2:0]                        ctl_s1_r;
	logic [2:0]                        ctl_s2_r;
	logic [3:0]                        pin_s1_r;
	logic [3:0]                        pin_s2_r;
	logic [pslv_pkg::DATA_W-1:0]       dat_s1_r;
	logic [pslv_pkg::DATA_W-1:0]       dat_s2_r;
	logic                              wr_act_r;
	logic                              rd_act_r;
	logic [1:0]                        phase_r;
	pslv_pkg::pslv_done_t              wdone_r;
	pslv_pkg::pslv_done_t              rdone_r;
	logic [pslv_pkg::DATA_W-1:0]       in_latch_r;
	logic [pslv_pkg::DATA_W-1:0]       out_latch_r;
	logic [pslv_pkg::DATA_W-1:0]       out_latch_nxt;
	pslv_pkg::pslv_dir_status_t        dstat_r;
	logic                              data_read_seen_r;
	logic                              irq_flag_r;
	logic [6:0]                        flag_rest_r;
	logic [7:0]                        enable_r;
	logic [7:0]                        conv_cfg_r;
	logic [2:0]                        port_latch_r;
	logic                              ready_r;

	logic                              wr_act;
	logic                              rd_act;
	logic                              wr_end;
	logic                              rd_end;
	logic                              wr_flag;
	logic                              rd_flag;
	logic                              acc_done;
	logic                              sw_wr;
	logic                              sw_rd;
	logic [7:0]                        idx;
	logic                              mapped;
	logic [7:0]                        wbyte;
	logic                              pins_analog;
	logic [7:0]                        rd_mux;

	assign idx         = paddr[pslv_pkg::ADDR_W-1:2];
	assign wbyte       = pwdata[7:0];
	assign acc_done    = psel && penable && ready_r;
	assign sw_wr       = acc_done && pwrite;
	assign sw_rd       = acc_done && !pwrite;
	assign pins_analog = conv_cfg_r[3:0] != pslv_pkg::CFG_ALL_DIGITAL;

	assign mapped = (idx == pslv_pkg::IDX_DATA_LATCH) || (idx == pslv_pkg::IDX_CTL_PINS)
		|| (idx == pslv_pkg::IDX_FLAG_REG) || (idx == pslv_pkg::IDX_DIR_STATUS)
		|| (idx == pslv_pkg::IDX_ENABLE_REG) || (idx == pslv_pkg::IDX_CONV_CFG);

	// strobe and pin synchronisers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_s1_r <= 3'h7;
			ctl_s2_r <= 3'h7;
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			dat_s1_r <= 8'h00;
			dat_s2_r <= 8'h00;
		end
		else
		begin
			ctl_s1_r <= ctl_in[2:0];
			ctl_s2_r <= ctl_s1_r;
			pin_s1_r <= ctl_in;
			pin_s2_r <= pin_s1_r;
			dat_s1_r <= data_in;
			dat_s2_r <= dat_s1_r;
		end
	end

	// transfer detection from active-low strobes
	assign wr_act = dstat_r.slave_mode_select && !ctl_s2_r[pslv_pkg::CTL_CS]
		&& !ctl_s2_r[pslv_pkg::CTL_WR];
	assign rd_act = dstat_r.slave_mode_select && !ctl_s2_r[pslv_pkg::CTL_CS]
		&& !ctl_s2_r[pslv_pkg::CTL_RD];
	assign wr_end = wr_act_r && !wr_act;
	assign rd_end = rd_act_r && !rd_act;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_act_r <= 1'b0;
			rd_act_r <= 1'b0;
		end
		else
		begin
			wr_act_r <= wr_act;
			rd_act_r <= rd_act;
		end
	end

	// four-phase frame counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_r <= 2'h0;
		else
			phase_r <= phase_r + 2'h1;
	end

	// completion timing: phase four after the next phase two
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdone_r <= pslv_pkg::DONE_IDLE;
		else
		begin
			case (wdone_r)
				pslv_pkg::DONE_IDLE:
					if (wr_end)
						wdone_r <= pslv_pkg::DONE_WAIT_TWO;
				pslv_pkg::DONE_WAIT_TWO:
					if (phase_r == pslv_pkg::PHASE_TWO)
						wdone_r <= pslv_pkg::DONE_WAIT_FOUR;
				pslv_pkg::DONE_WAIT_FOUR:
					if (phase_r == pslv_pkg::PHASE_FOUR)
						wdone_r <= wr_end ? pslv_pkg::DONE_WAIT_TWO : pslv_pkg::DONE_IDLE;
				default:
					wdone_r <= pslv_pkg::DONE_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdone_r <= pslv_pkg::DONE_IDLE;
		else
		begin
			case (rdone_r)
				pslv_pkg::DONE_IDLE:
					if (rd_end)
						rdone_r <= pslv_pkg::DONE_WAIT_TWO;
				pslv_pkg::DONE_WAIT_TWO:
					if (phase_r == pslv_pkg::PHASE_TWO)
						rdone_r <= pslv_pkg::DONE_WAIT_FOUR;
				pslv_pkg::DONE_WAIT_FOUR:
					if (phase_r == pslv_pkg::PHASE_FOUR)
						rdone_r <= rd_end ? pslv_pkg::DONE_WAIT_TWO : pslv_pkg::DONE_IDLE;
				default:
					rdone_r <= pslv_pkg::DONE_IDLE;
			endcase
		end
	end

	assign wr_flag = (wdone_r == pslv_pkg::DONE_WAIT_FOUR) && (phase_r == pslv_pkg::PHASE_FOUR);
	assign rd_flag = (rdone_r == pslv_pkg::DONE_WAIT_FOUR) && (phase_r == pslv_pkg::PHASE_FOUR);

	// input latch: captured at the end of an external write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			in_latch_r <= pslv_pkg::REG8_RESET;
		else if (wr_end)
			in_latch_r <= dat_s2_r;
	end

	// output latch written by software only
	assign out_latch_nxt = (sw_wr && idx == pslv_pkg::IDX_DATA_LATCH) ? wbyte : out_latch_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_latch_r <= pslv_pkg::REG8_RESET;
		else
			out_latch_r <= out_latch_nxt;
	end

	// data pin drive follows strobes in slave mode only, never pin_direction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			data_out <= 8'h00;
			data_oe  <= 8'h00;
		end
		else
		begin
			data_out <= out_latch_nxt;
			data_oe  <= {pslv_pkg::DATA_W{rd_act}};
		end
	end

	// direction, mode and status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dstat_r.pin_direction       <= pslv_pkg::DIR_RESET;
			dstat_r.pin3_direction_stub <= 1'b1;
			dstat_r.slave_mode_select   <= 1'b0;
			dstat_r.input_overflow_flag <= 1'b0;
			dstat_r.input_full_flag     <= 1'b0;
			dstat_r.output_full_flag    <= 1'b0;
		end
		else
		begin
			dstat_r.pin3_direction_stub <= 1'b1;
			if (sw_wr && idx == pslv_pkg::IDX_DIR_STATUS)
			begin
				dstat_r.pin_direction     <= wbyte[2:0];
				dstat_r.slave_mode_select <= wbyte[pslv_pkg::BIT_MODE];
			end
			// overflow: set wins over the software clear
			if (wr_flag && dstat_r.input_full_flag)
				dstat_r.input_overflow_flag <= 1'b1;
			else if (sw_wr && idx == pslv_pkg::IDX_DIR_STATUS)
			begin
				if (wbyte[pslv_pkg::BIT_IN_OVF])
					dstat_r.input_overflow_flag <= 1'b1;
				else if (data_read_seen_r)
					dstat_r.input_overflow_flag <= 1'b0;
			end
			// input full
			if (!dstat_r.slave_mode_select)
				dstat_r.input_full_flag <= 1'b0;
			else if (wr_flag)
				dstat_r.input_full_flag <= 1'b1;
			else if (sw_rd && idx == pslv_pkg::IDX_DATA_LATCH)
				dstat_r.input_full_flag <= 1'b0;
			// output full
			if (!dstat_r.slave_mode_select || rd_act)
				dstat_r.output_full_flag <= 1'b0;
			else if (sw_wr && idx == pslv_pkg::IDX_DATA_LATCH)
				dstat_r.output_full_flag <= 1'b1;
		end
	end

	// a data read arms the overflow clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_read_seen_r <= 1'b0;
		else if (sw_rd && idx == pslv_pkg::IDX_DATA_LATCH)
			data_read_seen_r <= 1'b1;
		else if (sw_wr && idx == pslv_pkg::IDX_DIR_STATUS && !wbyte[pslv_pkg::BIT_IN_OVF])
			data_read_seen_r <= 1'b0;
	end

	// flag and enable registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_flag_r  <= 1'b0;
			flag_rest_r <= 7'h00;
			enable_r    <= pslv_pkg::REG8_RESET;
			conv_cfg_r  <= pslv_pkg::REG8_RESET;
		end
		else
		begin
			if (wr_flag || rd_flag)
				irq_flag_r <= 1'b1;
			else if (sw_wr && idx == pslv_pkg::IDX_FLAG_REG)
				irq_flag_r <= wbyte[pslv_pkg::BIT_XFER_IRQ];
			if (sw_wr && idx == pslv_pkg::IDX_FLAG_REG)
				flag_rest_r <= wbyte[6:0];
			if (sw_wr && idx == pslv_pkg::IDX_ENABLE_REG)
				enable_r <= wbyte;
			if (sw_wr && idx == pslv_pkg::IDX_CONV_CFG)
				conv_cfg_r <= wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			transfer_irq <= 1'b0;
		else
			transfer_irq <= irq_flag_r && enable_r[pslv_pkg::BIT_XFER_IRQ];
	end

	// control pins as general outputs, also in slave mode; enables follow pin_direction only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_latch_r <= 3'h0;
		else if (sw_wr && idx == pslv_pkg::IDX_CTL_PINS)
			port_latch_r <= wbyte[2:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_out <= 3'h0;
			ctl_oe  <= 3'h0;
		end
		else
		begin
			ctl_out <= port_latch_r;
			ctl_oe  <= ~dstat_r.pin_direction;
		end
	end

	// register read multiplexer
	always_comb
	begin
		rd_mux = 8'h00;
		case (idx)
			pslv_pkg::IDX_DATA_LATCH:
				rd_mux = wr_act ? dat_s2_r : in_latch_r;
			pslv_pkg::IDX_CTL_PINS:
				rd_mux = {4'h0, pin_s2_r[3], pins_analog ? 3'h0 : pin_s2_r[2:0]};
			pslv_pkg::IDX_FLAG_REG:
				rd_mux = {irq_flag_r, flag_rest_r};
			pslv_pkg::IDX_DIR_STATUS:
				rd_mux = dstat_r;
			pslv_pkg::IDX_ENABLE_REG:
				rd_mux = enable_r;
			pslv_pkg::IDX_CONV_CFG:
				rd_mux = conv_cfg_r;
			default:
				rd_mux = 8'h00;
		endcase
	end

	// apb answer: one wait state, ready for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_r <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			ready_r <= psel && penable && !ready_r;
			if (psel && penable && !ready_r)
			begin
				prdata  <= pwrite ? 32'h00000000 : {24'h000000, rd_mux};
				pslverr <= !mapped;
			end
			else
			begin
				prdata  <= 32'h00000000;
				pslverr <= 1'b0;
			end
		end
	end

	assign pready = ready_r;

endmodule

// ### sim/pslv_ext_master.sv
`timescale 1ns/100ps
module pslv_ext_master
(
	// clock
	input  wire logic       pclk,
	// data pins
	input  wire logic [7:0] data_out,
	input  wire logic [7:0] data_oe,
	output logic      [7:0] data_in,
	// strobes
	output logic      [3:0] ctl_in
);
	logic       drv;
	logic [7:0] val;
	logic [7:0] last;
	// undriven bus shows inverse of last level
	assign data_in = (data_oe == 8'hFF) ? data_out : drv ? val : ~last;
	always @(posedge pclk)
		last <= data_in;
	initial
	begin
		drv = 1'b0;
		val = 8'h00;
		last = 8'h00;
		ctl_in = 4'hF;
	end
	task automatic wr(input logic [7:0] d);
		@(posedge pclk);
		val <= d;
		drv <= 1'b1;
		ctl_in <= 4'h9;
		repeat (6) @(posedge pclk);
		ctl_in <= 4'hF;
		repeat (3) @(posedge pclk);
		drv <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
	task automatic rd(output logic [7:0] a, output logic [7:0] b);
		@(posedge pclk);
		ctl_in <= 4'hA;
		repeat (6) @(posedge pclk);
		a = data_in;
		repeat (12) @(posedge pclk);
		b = data_in;
		ctl_in <= 4'hF;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// ### sim/pslv_port_assertions.sv
`timescale 1ns/100ps
module pslv_port_assertions
(
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic [7:0]  data_in,
	input wire logic [7:0]  data_out,
	input wire logic [7:0]  data_oe,
	input wire logic [3:0]  ctl_in,
	input wire logic [2:0]  ctl_out,
	input wire logic [2:0]  ctl_oe,
	input wire logic        transfer_irq
);
	logic mapped;
	logic wr_lat;
	assign mapped = paddr[9:2] inside {pslv_pkg::IDX_DATA_LATCH, pslv_pkg::IDX_CTL_PINS, pslv_pkg::IDX_FLAG_REG,
		pslv_pkg::IDX_DIR_STATUS, pslv_pkg::IDX_ENABLE_REG, pslv_pkg::IDX_CONV_CFG};
	assign wr_lat = pready && pwrite && paddr[9:2] == pslv_pkg::IDX_DATA_LATCH;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rdy_wait;
		$rose(psel && penable) |-> !pready ##1 pready;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait");
	property p_rdy_pulse;
		pready |-> psel && penable ##1 !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready pulse wrong");
	property p_err_map;
		pready && !mapped |-> pslverr && prdata == 32'h0;
	endproperty
	a_err_map: assert property (p_err_map) else $error("unmapped not refused");
	property p_err_only;
		pslverr |-> pready && !mapped;
	endproperty
	a_err_only: assert property (p_err_only) else $error("stray error");
	property p_rd_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
	property p_rd_upper;
		pready |-> prdata[31:8] == 24'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_oe_rise;
		data_oe != 8'h00 |-> data_oe == 8'hFF && $past(!ctl_in[0] && !ctl_in[2], 3);
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive without read strobe");
	property p_oe_fall;
		$fell(data_oe[0]) |-> $past(ctl_in[0] || ctl_in[2], 3);
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("release without strobe end");
	property p_dout_sw;
		data_oe[0] && $past(data_oe[0]) && $changed(data_out) |-> $past(wr_lat) || $past(wr_lat, 2);
	endproperty
	a_dout_sw: assert property (p_dout_sw) else $error("driven data changed alone");
	c_ext_read: cover property ($rose(data_oe[0]));
	c_err: cover property (pslverr);
	c_wr_in_read: cover property (wr_lat && data_oe[0]);
endmodule

bind pslv_port pslv_port_assertions pslv_port_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .data_in, .data_out, .data_oe, .ctl_in, .ctl_out, .ctl_oe, .transfer_irq);

// ### sim/pslv_port_tb_top.sv
`timescale 1ns/100ps
module pslv_port_tb_top;
	localparam logic [7:0] DAT = pslv_pkg::IDX_DATA_LATCH;
	localparam logic [7:0] CTL = pslv_pkg::IDX_CTL_PINS;
	localparam logic [7:0] FLG = pslv_pkg::IDX_FLAG_REG;
	localparam logic [7:0] DIR = pslv_pkg::IDX_DIR_STATUS;
	localparam logic [7:0] ENA = pslv_pkg::IDX_ENABLE_REG;
	localparam logic [7:0] CFG = pslv_pkg::IDX_CONV_CFG;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        transfer_irq;
	logic        err;
	logic [9:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic [7:0]  data_oe;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [3:0]  ctl_in;
	logic [2:0]  ctl_out;
	logic [2:0]  ctl_oe;
	int          n_fail;
	int          n_tests;
	int          cyc;
	pslv_port pslv_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .data_in, .data_out, .data_oe, .ctl_in, .ctl_out, .ctl_oe, .transfer_irq);
	pslv_ext_master pslv_ext_master_i (.pclk, .data_out, .data_oe, .data_in, .ctl_in);
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic finish_test;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask
	task automatic rr(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h0;
		n_fail = 0;
		n_tests = 0;
		cyc = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rr(DIR, 8'h0F);
		rr(FLG, 8'h00);
		rr(ENA, 8'h00);
		rr(CFG, 8'h00);
		rr(CTL, 8'h08);
		rr(8'h40, 8'h00);
		chk({31'h0, err}, 32'h1);
		wr(DIR, 8'h02);
		wr(CTL, 8'h05);
		repeat (2) @(posedge pclk);
		chk({29'h0, ctl_oe}, 32'h5);
		chk({29'h0, ctl_out}, 32'h5);
		rr(DIR, 8'h0A);
		wr(CFG, 8'h0F);
		wr(DIR, 8'h17);
		rr(CTL, 8'h0F);
		pslv_ext_master_i.wr(8'h5A);
		rr(DIR, 8'h9F);
		rr(FLG, 8'h80);
		chk({31'h0, transfer_irq}, 32'h0);
		wr(ENA, 8'h80);
		repeat (2) @(posedge pclk);
		chk({31'h0, transfer_irq}, 32'h1);
		pslv_ext_master_i.wr(8'hC3);
		rr(DIR, 8'hBF);
		wr(DIR, 8'h17);
		rr(DIR, 8'hBF);
		rr(DAT, 8'hC3);
		rr(DIR, 8'h3F);
		wr(DIR, 8'h17);
		rr(DIR, 8'h1F);
		wr(FLG, 8'h00);
		rr(FLG, 8'h00);
		repeat (2) @(posedge pclk);
		chk({31'h0, transfer_irq}, 32'h0);
		fork
			pslv_ext_master_i.wr(8'h96);
			begin
				repeat (4) @(posedge pclk);
				rr(DAT, 8'h96);
			end
		join
		wr(DIR, 8'h07);
		rr(DIR, 8'h0F);
		fork
			pslv_ext_master_i.rd(a, b);
			begin
				repeat (8) @(posedge pclk);
				chk({24'h0, data_oe}, 32'h0);
			end
		join
		wr(DIR, 8'h17);
		wr(FLG, 8'h00);
		wr(DAT, 8'h3C);
		rr(DIR, 8'h5F);
		fork
			pslv_ext_master_i.rd(a, b);
			begin
				repeat (8) @(posedge pclk);
				wr(DAT, 8'h77);
			end
		join
		chk({24'h0, a}, 32'h3C);
		chk({24'h0, b}, 32'h77);
		rr(DIR, 8'h1F);
		rr(FLG, 8'h80);
		chk({24'h0, data_oe}, 32'h0);
		finish_test();
	end
endmodule
